// File: verilog/drive_status_pkg.sv
package drive_status_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_INPUT_CFG = 8'h04;
  localparam logic [7:0] OFS_ALARM_LO = 8'h08;
  localparam logic [7:0] OFS_ALARM_HI = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CONDITIONS = 8'h14;

  // field positions
  localparam int SEL_W = 5;
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 8;
  localparam int SEL_RELAY_LSB = 16;
  localparam int MODE_LSB = 0;
  localparam int LOSS_LSB = 4;
  localparam int LIM_W = 16;
  localparam int STAT_FAULT = 0;
  localparam int STAT_LOCK = 1;
  localparam int STAT_RUN = 2;
  localparam int STAT_FLW_FAULT = 3;
  localparam int STAT_CNT_LSB = 4;

  // ------------------------------------------------------------
  // modes and indication selections
  // ------------------------------------------------------------
  localparam logic [1:0] FIN_TRIP_NO = 2'h0;
  localparam logic [1:0] FIN_TRIP_NC = 2'h1;
  localparam logic [1:0] FIN_TRIP_RESET = 2'h2;
  localparam logic [1:0] LOSS_FAULT = 2'h0;
  localparam logic [1:0] LOSS_PRESET4 = 2'h1;
  localparam logic [1:0] LOSS_MIN_SPEED = 2'h2;

  localparam int NCOND = 19;
  localparam logic [4:0] SEL_NONE = 5'h00;
  localparam logic [4:0] SEL_RUN = 5'h01;
  localparam logic [4:0] SEL_FAULT = 5'h02;
  localparam logic [4:0] SEL_INV_FAULT = 5'h03;
  localparam logic [4:0] SEL_LOCKOUT = 5'h04;
  localparam logic [4:0] SEL_AT_SPEED = 5'h05;
  localparam logic [4:0] SEL_ABOVE3 = 5'h06;
  localparam logic [4:0] SEL_CURRENT_LIMITED_IND = 5'h07;
  localparam logic [4:0] SEL_AUTO = 5'h08;
  localparam logic [4:0] SEL_FOLLOWER = 5'h09;
  localparam logic [4:0] SEL_REVERSE = 5'h0A;
  localparam logic [4:0] SEL_WINDOW = 5'h0B;
  localparam logic [4:0] SEL_INV_WINDOW = 5'h0C;
  localparam logic [4:0] SEL_LOW = 5'h0D;
  localparam logic [4:0] SEL_INV_LOW = 5'h0E;
  localparam logic [4:0] SEL_HIGH = 5'h0F;
  localparam logic [4:0] SEL_INV_HIGH = 5'h10;
  localparam logic [4:0] SEL_SLEEP = 5'h11;
  localparam logic [4:0] SEL_ZERO = 5'h12;

  // ------------------------------------------------------------
  // thresholds (frequency in 0.01 Hz, loop current in 0.01 mA)
  // ------------------------------------------------------------
  localparam logic [15:0] RUN_STOP_FREQ = 16'h0032;
  localparam logic [15:0] AT_SPEED_BAND = 16'h0032;
  localparam logic [15:0] FOLLOWER_MIN = 16'h00C8;
  localparam logic [2:0] RESTART_LIMIT = 3'h5;
  localparam int CLK_HZ = 100000000;
  localparam int CURRENT_LIMITED_IND_HOLD_MS = 500;
  localparam int CURRENT_LIMITED_IND_HOLD_CYC_DEF = CURRENT_LIMITED_IND_HOLD_MS * (CLK_HZ / 1000);
  localparam int HOLD_W = 26;

  typedef enum logic [1:0] {
    BUS_ADDR = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_t;
endpackage

// File: verilog/drive_status_output_select.sv
// ------------------------------------------------------------
// Notes on behaviour
// ------------------------------------------------------------
// Notes on behaviour
// R1 - normally open contact closed trips external fault
// R2 - normally closed contact opened trips external fault
// R3 - reset mode: closed contact clears active fault
// R4 - reset mode: only contact and keypad clear
// R5 - each output selectable; none holds it off
// R6 - second output has own identical selector
// R7 - relay has own selector, same choices
// R8 - second relay follows first output selection
// R9 - run: start until trip or stopped below 0.5Hz
// R10 - fault healthy while powered, drops on trip
// R11 - inverse fault set on trip until cleared
// R12 - lockout drops after five failed restarts
// R13 - at speed with 0.50 Hz hysteresis band
// R14 - above speed while frequency exceeds preset three
// R15 - current limit indication held at least 500ms
// R16 - auto mode and reverse direction indications
// R17 - follower present while loop above 2 mA
// R18 - window alarm between limits, inverse opposite
// R19 - low alarm below low limit, inverse opposite
// R20 - high alarm above high limit, inverse opposite
// R21 - sleep indication; zero output for any reason
// R22 - lost 4-20 mA follower acts by selection
// R23 - registered inputs, registered output multiplexers
//
// The AHB-Lite slave port and the address map are this design's own decisions.
module drive_status_output_select #(
  parameter int unsigned CURRENT_LIMITED_IND_HOLD_CYC = drive_status_pkg::CURRENT_LIMITED_IND_HOLD_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_fault_contact_input,
  input wire logic i_remote_stop_input,
  input wire logic i_keypad_stop,
  input wire logic i_start_cmd,
  input wire logic i_stop_cmd,
  input wire logic i_internal_trip,
  input wire logic i_restart_failed,
  input wire logic [15:0] i_out_freq,
  input wire logic [15:0] i_speed_setpoint,
  input wire logic [15:0] i_preset3_speed,
  input wire logic [15:0] i_current_loop_reference_input,
  input wire logic i_follower_is_4_20,
  input wire logic [15:0] i_feedback,
  input wire logic [15:0] i_speed_ref,
  input wire logic i_closed_loop,
  input wire logic i_current_limit,
  input wire logic i_auto_mode,
  input wire logic i_reverse,
  input wire logic i_sleep,
  input wire logic i_large_model,
  output logic o_open_collector_out_a,
  output logic o_open_collector_out_b,
  output logic o_relay_main,
  output logic o_relay_second,
  output logic o_fault_active,
  output logic o_follower_fault,
  output logic o_goto_preset4,
  output logic o_goto_min_speed
);
  import drive_status_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic pick(input logic [NCOND-1:0] c, input logic [SEL_W-1:0] s);
    pick = (s == SEL_NONE || s > SEL_ZERO) ? 1'b0 : c[s - 5'h01];
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // ------------------------------------------------------------
  // input registers
  // ------------------------------------------------------------
  logic fc_q, rstop_q, kstop_q, start_q, stop_q, itrip_q, rfail_q, f420_q;
  logic cloop_q, clim_q, auto_q, rev_q, sleep_q, large_q;
  logic [15:0] freq_q, setp_q, pre3_q, loop_q, fb_q, sref_q;

  // status sampled once so every condition sees one coherent snapshot
  always_ff @(posedge i_clk) begin // see R23
    fc_q <= i_fault_contact_input;
    rstop_q <= i_remote_stop_input;
    kstop_q <= i_keypad_stop;
    start_q <= i_start_cmd;
    stop_q <= i_stop_cmd;
    itrip_q <= i_internal_trip;
    rfail_q <= i_restart_failed;
    f420_q <= i_follower_is_4_20;
    cloop_q <= i_closed_loop;
    clim_q <= i_current_limit;
    auto_q <= i_auto_mode;
    rev_q <= i_reverse;
    sleep_q <= i_sleep;
    large_q <= i_large_model;
    freq_q <= i_out_freq;
    setp_q <= i_speed_setpoint;
    pre3_q <= i_preset3_speed;
    loop_q <= i_current_loop_reference_input;
    fb_q <= i_feedback;
    sref_q <= i_speed_ref;
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [31:0] select_q;
  logic [1:0] mode_q, loss_q;
  logic [LIM_W-1:0] lo_q, hi_q;
  wire [SEL_W-1:0] sel_a = select_q[SEL_A_LSB +: SEL_W];
  wire [SEL_W-1:0] sel_b = select_q[SEL_B_LSB +: SEL_W];
  wire [SEL_W-1:0] sel_r = select_q[SEL_RELAY_LSB +: SEL_W];

  // ------------------------------------------------------------
  // fault trip and clear
  // ------------------------------------------------------------
  logic fault_q, run_q, stop_pend_q, atspd_q, ilim_q, flw_fault_q;
  logic [2:0] fail_cnt_q;
  logic [HOLD_W-1:0] hold_q;

  wire reset_mode = (mode_q == FIN_TRIP_RESET);
  wire ext_trip = (mode_q == FIN_TRIP_NO && fc_q) || (mode_q == FIN_TRIP_NC && !fc_q); // see R1 see R2
  wire clear_src = reset_mode ? (fc_q || kstop_q) : (rstop_q || kstop_q); // see R3 see R4
  wire follower_low = loop_q < FOLLOWER_MIN;
  wire follower_lost = f420_q && follower_low; // see R22
  wire trip = ext_trip || itrip_q || (follower_lost && loss_q == LOSS_FAULT);

  // a trip arriving together with a clear wins
  always_ff @(posedge i_clk) begin // see R10 see R11
    if (i_sys_rst) begin
      fault_q <= 1'b0;
    end else if (trip) begin
      fault_q <= 1'b1;
    end else if (clear_src) begin
      fault_q <= 1'b0;
    end
  end

  // follower loss actions; the fault choice latches with the trip
  always_ff @(posedge i_clk) begin // see R22
    if (i_sys_rst) begin
      flw_fault_q <= 1'b0;
    end else if (follower_lost && loss_q == LOSS_FAULT) begin
      flw_fault_q <= 1'b1;
    end else if (!fault_q || clear_src) begin
      flw_fault_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // restart lockout
  // ------------------------------------------------------------
  // failed attempts only count while faulted; a manual clear rearms
  always_ff @(posedge i_clk) begin // see R12
    if (i_sys_rst) begin
      fail_cnt_q <= 3'h0;
    end else if (fault_q && rfail_q && fail_cnt_q != RESTART_LIMIT) begin
      fail_cnt_q <= fail_cnt_q + 3'h1;
    end else if (!trip && clear_src) begin
      fail_cnt_q <= 3'h0;
    end
  end
  wire lock_ok = (fail_cnt_q != RESTART_LIMIT);

  // ------------------------------------------------------------
  // run indication
  // ------------------------------------------------------------
  wire run_end = trip || fault_q || (stop_pend_q && freq_q <= RUN_STOP_FREQ);
  always_ff @(posedge i_clk) begin // see R9
    if (i_sys_rst) begin
      run_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else if (start_q && !trip && !fault_q) begin
      run_q <= 1'b1;
      stop_pend_q <= 1'b0;
    end else if (run_end) begin
      run_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else if (stop_q && run_q) begin
      stop_pend_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // at speed hysteresis and current limit hold
  // ------------------------------------------------------------
  wire [15:0] spd_err = absdiff(freq_q, setp_q);
  // set only on reaching the setpoint; the band keeps the relay calm
  always_ff @(posedge i_clk) begin // see R13
    if (i_sys_rst) begin
      atspd_q <= 1'b0;
    end else if (spd_err == 16'h0000) begin
      atspd_q <= 1'b1;
    end else if (spd_err > AT_SPEED_BAND) begin
      atspd_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin // see R15
    if (i_sys_rst) begin
      ilim_q <= 1'b0;
      hold_q <= '0;
    end else if (!ilim_q && clim_q) begin
      ilim_q <= 1'b1;
      hold_q <= HOLD_W'(CURRENT_LIMITED_IND_HOLD_CYC - 1);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - HOLD_W'(1);
    end else if (!clim_q) begin
      ilim_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // condition vector, bit n is selection n+1
  // ------------------------------------------------------------
  wire [15:0] mon = cloop_q ? fb_q : sref_q;
  wire below_lo = mon < lo_q; // see R19
  wire above_hi = mon > hi_q; // see R20
  wire in_win = !below_lo && !above_hi; // see R18
  wire zero_out = !run_q || freq_q == 16'h0000 || sleep_q || fault_q; // see R21
  wire [NCOND-1:0] cond = {
    1'b0, zero_out, sleep_q, !above_hi, above_hi, !below_lo, below_lo, !in_win, in_win, // top bit spare
    rev_q, !follower_low, auto_q, ilim_q, freq_q > pre3_q, atspd_q, // see R14 see R16 see R17
    lock_ok, fault_q, !fault_q, run_q
  };

  // ------------------------------------------------------------
  // registered output multiplexers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin // see R5 see R6 see R7 see R8 see R23
    if (i_sys_rst) begin
      o_open_collector_out_a <= 1'b0;
      o_open_collector_out_b <= 1'b0;
      o_relay_main <= 1'b0;
      o_relay_second <= 1'b0;
      o_fault_active <= 1'b0;
      o_follower_fault <= 1'b0;
      o_goto_preset4 <= 1'b0;
      o_goto_min_speed <= 1'b0;
    end else begin
      o_open_collector_out_a <= pick(cond, sel_a);
      o_open_collector_out_b <= pick(cond, sel_b);
      o_relay_main <= pick(cond, sel_r);
      o_relay_second <= large_q && pick(cond, sel_a);
      o_fault_active <= fault_q;
      o_follower_fault <= flw_fault_q;
      o_goto_preset4 <= follower_lost && loss_q == LOSS_PRESET4; // see R22
      o_goto_min_speed <= follower_lost && loss_q == LOSS_MIN_SPEED;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave, one wait state per transfer
  // ------------------------------------------------------------
  bus_state_t bus_q;
  logic [7:0] addr_q;
  logic wr_q;
  wire take = i_hsel && i_htrans[1] && i_hready && bus_q == BUS_ADDR;
  wire hit_sel = addr_q == OFS_SELECT;
  wire hit_cfg = addr_q == OFS_INPUT_CFG;
  wire hit_lo = addr_q == OFS_ALARM_LO;
  wire hit_hi = addr_q == OFS_ALARM_HI;
  wire hit_st = addr_q == OFS_STATUS;
  wire hit_cd = addr_q == OFS_CONDITIONS;
  wire [31:0] status_word = {25'h0, fail_cnt_q, flw_fault_q, run_q, lock_ok, fault_q};
  wire [31:0] rd_mux =
    hit_sel ? select_q :
    hit_cfg ? {26'h0, loss_q, 2'h0, mode_q} :
    hit_lo ? {16'h0, lo_q} :
    hit_hi ? {16'h0, hi_q} :
    hit_st ? status_word :
    hit_cd ? {13'h0, cond} : 32'h0000_0000;
  wire do_wr = bus_q == BUS_DATA && wr_q;

  // the wait state lets a write land before any following read is sampled
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus_q <= BUS_ADDR;
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
    end else begin
      case (bus_q)
        BUS_ADDR: begin
          if (take) begin
            bus_q <= BUS_DATA;
            addr_q <= (i_haddr[31:8] == 24'h0) ? i_haddr[7:0] : 8'hFF;
            wr_q <= i_hwrite;
            o_hreadyout <= 1'b0;
          end
        end
        BUS_DATA: begin
          bus_q <= BUS_ADDR;
          o_hreadyout <= 1'b1;
          o_hrdata <= wr_q ? 32'h0000_0000 : rd_mux;
        end
        default: begin
          bus_q <= BUS_ADDR;
          o_hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // software writes; unmapped or read-only words ignore them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      select_q <= 32'h0000_0000;
      mode_q <= FIN_TRIP_NO;
      loss_q <= LOSS_FAULT;
      lo_q <= 16'h0000;
      hi_q <= 16'hFFFF;
    end else if (do_wr) begin
      if (hit_sel) select_q <= i_hwdata & 32'h001F_1F1F;
      if (hit_cfg) mode_q <= i_hwdata[MODE_LSB +: 2];
      if (hit_cfg) loss_q <= i_hwdata[LOSS_LSB +: 2];
      if (hit_lo) lo_q <= i_hwdata[LIM_W-1:0];
      if (hit_hi) hi_q <= i_hwdata[LIM_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_start;
    start_q && !trip && !fault_q;
  endsequence
  sequence s_stopped;
    stop_pend_q && freq_q <= RUN_STOP_FREQ && !start_q;
  endsequence
  property p_nc_trip;
    @(posedge i_clk) disable iff (i_sys_rst) (mode_q == FIN_TRIP_NC && !fc_q) |=> fault_q;
  endproperty
  a_nc_trip: assert property (p_nc_trip) else $error("open contact did not trip"); // see R2
  property p_no_trip;
    @(posedge i_clk) disable iff (i_sys_rst) (mode_q == FIN_TRIP_NO && fc_q) |=> ##1 o_fault_active;
  endproperty
  a_no_trip: assert property (p_no_trip) else $error("closed contact did not trip"); // see R1
  property p_reset_clear;
    @(posedge i_clk) disable iff (i_sys_rst) (reset_mode && fc_q && !trip) |=> !fault_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("contact did not clear fault"); // see R3
  property p_remote_ignored;
    @(posedge i_clk) disable iff (i_sys_rst)
      (reset_mode && fault_q && rstop_q && !fc_q && !kstop_q) |=> fault_q;
  endproperty
  a_remote_ignored: assert property (p_remote_ignored) else $error("remote stop cleared fault"); // see R4
  property p_run;
    @(posedge i_clk) disable iff (i_sys_rst) s_start |=> run_q;
  endproperty
  a_run: assert property (p_run) else $error("start did not set run"); // see R9
  property p_run_end;
    @(posedge i_clk) disable iff (i_sys_rst) s_stopped |=> !run_q;
  endproperty
  a_run_end: assert property (p_run_end) else $error("run outlived stop"); // see R9
  property p_none;
    @(posedge i_clk) disable iff (i_sys_rst) (sel_b == SEL_NONE) |=> !o_open_collector_out_b;
  endproperty
  a_none: assert property (p_none) else $error("none selection drove output"); // see R5
  property p_second_relay;
    @(posedge i_clk) disable iff (i_sys_rst) large_q |=> (o_relay_second == o_open_collector_out_a);
  endproperty
  a_second_relay: assert property (p_second_relay) else $error("second relay not following"); // see R8
  property p_ilim_hold;
    @(posedge i_clk) disable iff (i_sys_rst) $rose(ilim_q) |-> ilim_q [*8];
  endproperty
  a_ilim_hold: assert property (p_ilim_hold) else $error("current limit hold too short"); // see R15
  property p_lockout;
    @(posedge i_clk) disable iff (i_sys_rst) (fault_q && rfail_q && fail_cnt_q == RESTART_LIMIT - 3'h1) |=> !lock_ok;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout did not drop"); // see R12
  property p_preset4;
    @(posedge i_clk) disable iff (i_sys_rst) (follower_lost && loss_q == LOSS_PRESET4) |=> o_goto_preset4;
  endproperty
  a_preset4: assert property (p_preset4) else $error("follower loss action missing"); // see R22
endmodule // drive_status_output_select

// File: tb/drive_contacts_model.sv
// ------------------------------------------------------------
// far side: fault contact and indicator loads
// ------------------------------------------------------------
module drive_contacts_model (
  input wire logic i_clk,
  input wire logic i_close_cmd,
  input wire logic [3:0] i_sink,
  output logic o_contact_closed,
  output logic [3:0] o_load_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // contact moves just after an edge, never mid-cycle
  always @(posedge i_clk) begin
    o_contact_closed <= i_close_cmd;
  end
  // sinking outputs: a load is energised only while its output sinks
  assign o_load_on = i_sink;
endmodule // drive_contacts_model

// File: tb/drive_status_output_select_tb.sv
module drive_status_output_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drive_status_pkg::*;
  localparam int HOLD = 20;
  logic i_clk = '0, i_sys_rst = '1, i_hsel = '0, i_hwrite = '0, i_hready, contact_cmd = '0;
  logic [1:0] i_htrans = '0, lc[2];
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_haddr = '0, i_hwdata = '0, o_hrdata, q;
  logic o_hreadyout, o_hresp, o_open_collector_out_a, o_open_collector_out_b, o_relay_main, o_relay_second;
  logic o_fault_active, o_follower_fault, o_goto_preset4, o_goto_min_speed, i_fault_contact_input;
  logic i_remote_stop_input = '0, i_keypad_stop = '0, i_start_cmd = '0, i_stop_cmd = '0, i_internal_trip = '0;
  logic i_restart_failed = '0, i_follower_is_4_20 = '0, i_closed_loop = '0, i_current_limit = '0;
  logic i_auto_mode = '0, i_reverse = '0, i_sleep = '0, i_large_model = '0;
  logic [15:0] i_out_freq = '0, i_speed_setpoint = '0, i_preset3_speed = '0, i_current_loop_reference_input = '0;
  logic [15:0] i_feedback = '0, i_speed_ref = '0, fr, p3, lp, fb, sr, lo, hi, mon;
  logic [4:0] ca, cb, cr;
  logic [5:0] bits;
  logic [3:0] loads;
  logic low, high, win;
  int errors = 0, n_tests = 0, mv[20];
  integer seed = 32'h929B6DA1;

  assign i_hready = o_hreadyout;
  always #5 i_clk = ~i_clk;

  drive_status_output_select #(.CURRENT_LIMITED_IND_HOLD_CYC(HOLD)) uut (.i_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_fault_contact_input,
    .i_remote_stop_input, .i_keypad_stop, .i_start_cmd, .i_stop_cmd, .i_internal_trip, .i_restart_failed,
    .i_out_freq, .i_speed_setpoint, .i_preset3_speed, .i_current_loop_reference_input, .i_follower_is_4_20,
    .i_feedback, .i_speed_ref, .i_closed_loop, .i_current_limit, .i_auto_mode, .i_reverse, .i_sleep,
    .i_large_model, .o_open_collector_out_a, .o_open_collector_out_b, .o_relay_main, .o_relay_second,
    .o_fault_active, .o_follower_fault, .o_goto_preset4, .o_goto_min_speed);
  drive_contacts_model far_side (.i_clk, .i_close_cmd(contact_cmd), .o_contact_closed(i_fault_contact_input),
    .i_sink({o_relay_second, o_relay_main, o_open_collector_out_b, o_open_collector_out_a}), .o_load_on(loads));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // one single-word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk);
    i_hsel <= '1; i_htrans <= 2'h2; i_hwrite <= w; i_haddr <= {24'h0, a};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= '0; i_htrans <= 2'h0; i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic sel(input logic [4:0] a, input logic [4:0] b, input logic [4:0] r);
    wr(OFS_SELECT, {11'h0, r, 3'h0, b, 3'h0, a});
  endtask
  task automatic drv(input int k, input logic v);
    case (k)
      0: i_remote_stop_input <= v;
      1: i_keypad_stop <= v;
      2: i_start_cmd <= v;
      3: i_stop_cmd <= v;
      4: i_internal_trip <= v;
      5: i_restart_failed <= v;
      default: i_current_limit <= v;
    endcase
  endtask
  // covers input flop, state and output flop latency with margin
  task automatic pulse(input int k, input int n);
    @(posedge i_clk);
    drv(k, 1'b1);
    tick(n);
    drv(k, 1'b0);
    tick(7);
  endtask
  task automatic contact(input logic v);
    @(posedge i_clk);
    contact_cmd <= v;
    tick(8);
  endtask
  task automatic setv(input logic [15:0] f, input logic [15:0] sp, input logic [15:0] l);
    @(posedge i_clk);
    i_out_freq <= f; i_speed_setpoint <= sp; i_current_loop_reference_input <= l;
    tick(7);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(10);
    i_sys_rst <= '0;
    bus(1'b0, OFS_ALARM_HI, 32'h0, q); chk("alarm_hi", 32'h0000FFFF, q);
    chk("hresp", 32'h0, o_hresp);
    bus(1'b0, OFS_INPUT_CFG, 32'h0, q); chk("input_cfg", 32'h0, q);
    wr(8'h20, 32'h5A5A5A5A); bus(1'b0, 8'h20, 32'h0, q); chk("unmapped", 32'h0, q);
    wr(OFS_STATUS, 32'hFF); bus(1'b0, OFS_STATUS, 32'h0, q); chk("status", 32'h2, q);
    // random conditions against the model while nothing is running or faulted
    for (int i = 0; i < 40; i++) begin
      fr = 16'($random(seed)) >> 2; p3 = 16'($random(seed)); lp = 16'($random(seed)) % 16'h0190;
      fb = 16'($random(seed)); sr = 16'($random(seed)); lo = 16'($random(seed)); hi = 16'($random(seed));
      bits = 6'($random(seed));
      ca = 5'(i % 20); cb = 5'((i + 7) % 20); cr = 5'((i + 13) % 20);
      @(posedge i_clk);
      i_out_freq <= fr; i_speed_setpoint <= fr + 16'h4000; i_preset3_speed <= p3; i_feedback <= fb;
      i_current_loop_reference_input <= lp; i_speed_ref <= sr; i_closed_loop <= bits[0];
      i_auto_mode <= bits[1]; i_reverse <= bits[2]; i_sleep <= bits[3]; i_large_model <= bits[4];
      wr(OFS_ALARM_LO, {16'h0, lo});
      wr(OFS_ALARM_HI, {16'h0, hi});
      sel(ca, cb, cr);
      tick(4);
      mon = bits[0] ? fb : sr;
      low = mon < lo; high = mon > hi; win = !low && !high;
      mv = '{0, 0, 1, 0, 1, 0, fr > p3, 0, bits[1], lp >= 16'h00C8, bits[2], win, !win, low, !low, high,
             !high, bits[3], 1, 0};
      chk("out_a", mv[ca], loads[0]);
      chk("out_b", mv[cb], loads[1]);
      chk("relay", mv[cr], loads[2]);
      chk("relay2", bits[4] ? mv[ca] : 0, loads[3]);
    end
    @(posedge i_clk);
    i_sleep <= '0;
    // fault contact in each mode, and who may clear
    sel(SEL_INV_FAULT, SEL_FAULT, SEL_ZERO);
    contact(1'b1); chk("fault", 1, o_fault_active);
    chk("inv_fault", 1, o_open_collector_out_a); chk("healthy", 0, o_open_collector_out_b);
    chk("zero", 1, o_relay_main);
    contact(1'b0); chk("fault_held", 1, o_fault_active);
    pulse(0, 2); chk("cleared", 0, o_fault_active); chk("healthy", 1, o_open_collector_out_b);
    contact(1'b1); wr(OFS_INPUT_CFG, {30'h0, FIN_TRIP_NC}); pulse(0, 2);
    chk("nc_closed", 0, o_fault_active);
    contact(1'b0); chk("nc_open", 1, o_fault_active);
    contact(1'b1); pulse(0, 2); wr(OFS_INPUT_CFG, {30'h0, FIN_TRIP_RESET});
    contact(1'b0); pulse(4, 1); chk("trip", 1, o_fault_active);
    pulse(0, 2); chk("remote_ignored", 1, o_fault_active);
    contact(1'b1); chk("contact_clear", 0, o_fault_active);
    contact(1'b0); pulse(4, 1); pulse(1, 2); chk("keypad_clear", 0, o_fault_active);
    // lockout drops on the fifth failed restart only
    sel(SEL_LOCKOUT, SEL_NONE, SEL_NONE); pulse(4, 1);
    repeat (4) pulse(5, 1);
    chk("lock4", 1, o_open_collector_out_a);
    pulse(5, 1); chk("lock5", 0, o_open_collector_out_a);
    bus(1'b0, OFS_STATUS, 32'h0, q); chk("restarts", 5, q[6:4]);
    pulse(1, 2); chk("lock_clear", 1, o_open_collector_out_a);
    // run, at speed hysteresis and zero output
    sel(SEL_RUN, SEL_ZERO, SEL_AT_SPEED); setv(16'd100, 16'd100, 16'd300);
    pulse(2, 1); chk("run", 1, o_open_collector_out_a); chk("zero", 0, o_open_collector_out_b);
    chk("at_speed", 1, o_relay_main);
    setv(16'd150, 16'd100, 16'd300); chk("in_band", 1, o_relay_main);
    setv(16'd151, 16'd100, 16'd300); chk("out_band", 0, o_relay_main);
    setv(16'd51, 16'd100, 16'd300); pulse(3, 1); chk("stopping", 1, o_open_collector_out_a);
    setv(16'd50, 16'd100, 16'd300); chk("stopped", 0, o_open_collector_out_a);
    pulse(2, 1); pulse(4, 1); chk("trip_stops", 0, o_open_collector_out_a);
    pulse(1, 2);
    // current limit indication minimum hold
    sel(SEL_CURRENT_LIMITED_IND, SEL_NONE, SEL_NONE); pulse(6, 1);
    chk("ilim_on", 1, o_open_collector_out_a); tick(HOLD - 5); chk("ilim_hold", 1, o_open_collector_out_a);
    tick(7); chk("ilim_off", 0, o_open_collector_out_a);
    pulse(6, HOLD + 10); chk("ilim_release", 0, o_open_collector_out_a);
    // lost follower: each action
    sel(SEL_FOLLOWER, SEL_NONE, SEL_NONE);
    @(posedge i_clk);
    i_follower_is_4_20 <= '1;
    lc = '{LOSS_PRESET4, LOSS_MIN_SPEED};
    for (int k = 0; k < 2; k++) begin
      wr(OFS_INPUT_CFG, {26'h0, lc[k], 4'h0}); setv(16'd50, 16'd0, 16'd100);
      chk("follower", 0, o_open_collector_out_a);
      chk("preset4", k == 0, o_goto_preset4); chk("min_speed", k == 1, o_goto_min_speed);
      setv(16'd50, 16'd0, 16'd300);
    end
    wr(OFS_INPUT_CFG, 32'h0); setv(16'd50, 16'd0, 16'd100);
    chk("loss_fault", 1, o_fault_active); chk("follower_fault", 1, o_follower_fault);
    end_of_test();
  end

  // watchdog well beyond the roughly 1200 cycles the sequence needs
  initial begin
    #200us;
    errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule // drive_status_output_select_tb
